/* irq_pkg.sv */
// irq_pkg: shared constants, types and helpers of the interrupt block
// assumes one system clock and an 8-bit register port with 4-bit address
package irq_pkg;

  // register port widths
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register offsets on the plain port
  localparam logic [3:0] OFS_EDGE_SEL = 4'h0;
  localparam logic [3:0] OFS_CTRL_A = 4'h1;
  localparam logic [3:0] OFS_CTRL_B = 4'h2;
  localparam logic [3:0] OFS_CTRL_C = 4'h3;
  localparam logic [3:0] OFS_GROUP0 = 4'h4;
  localparam logic [3:0] OFS_GROUP1 = 4'h5;
  localparam logic [3:0] OFS_GROUP2 = 4'h6;
  localparam logic [3:0] OFS_GROUP3 = 4'h7;
  localparam logic [3:0] OFS_EVT_STATUS = 4'h8;
  localparam logic [3:0] OFS_EVT_CLEAR = 4'h9;
  localparam logic [3:0] OFS_EVT_ENABLE = 4'ha;

  // reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // edge select layout; upper nibble unimplemented
  localparam int PIN0_SEL_LSB = 0;
  localparam int PIN1_SEL_LSB = 2;
  localparam logic [7:0] EDGE_SEL_MASK = 8'h0f;

  // primary control a
  localparam int A_GLOBAL_EN = 0;
  localparam int A_PIN0_EN = 1;
  localparam int A_PIN1_EN = 2;
  localparam int A_MF0_EN = 3;
  localparam int A_PIN0_FLAG = 4;
  localparam int A_PIN1_FLAG = 5;
  localparam int A_MF0_FLAG = 6;

  // primary control b
  localparam int B_ADC_EN = 0;
  localparam int B_TB0_EN = 1;
  localparam int B_TB1_EN = 2;
  localparam int B_MF1_EN = 3;
  localparam int B_ADC_FLAG = 4;
  localparam int B_TB0_FLAG = 5;
  localparam int B_TB1_FLAG = 6;
  localparam int B_MF1_FLAG = 7;

  // primary control c
  localparam int C_MF2_EN = 0;
  localparam int C_MF3_EN = 1;
  localparam int C_MF2_FLAG = 4;
  localparam int C_MF3_FLAG = 5;

  // group registers: flags in upper nibble, enables in lower
  localparam int GROUP_FLAG_LSB = 4;
  localparam logic [3:0] GROUP0_MASK = 4'h3;
  localparam logic [3:0] GROUP1_MASK = 4'hf;
  localparam logic [3:0] GROUP2_MASK = 4'hb;
  localparam logic [3:0] GROUP3_MASK = 4'h3;

  // event status bits
  localparam int EVT_PIN0 = 0;
  localparam int EVT_PIN1 = 1;
  localparam int EVT_TB0 = 2;
  localparam int EVT_TB1 = 3;
  localparam int EVT_ADC = 4;
  localparam int EVT_GROUP = 5;
  localparam int EVT_REQ = 6;
  localparam int EVT_STACK_HOLD = 7;

  // core pending vector positions
  localparam int PEND_PIN0 = 0;
  localparam int PEND_PIN1 = 1;
  localparam int PEND_MF0 = 2;
  localparam int PEND_ADC = 3;
  localparam int PEND_TB0 = 4;
  localparam int PEND_TB1 = 5;
  localparam int PEND_MF1 = 6;
  localparam int PEND_MF2 = 7;
  localparam int PEND_MF3 = 8;
  localparam int PEND_W = 9;

  // edge detector modes
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;

  // one register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // sticky flag update: hardware set wins over a software write
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic wr, input logic wval);
    return set | (wr ? wval : cur);
  endfunction

endpackage

/* pin_edge_detect.sv */
// pin_edge_detect: selectable edge detector for one external pin
// assumes the pin is already synchronous to clock
module pin_edge_detect
  import irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pin,
  input wire edge_mode_t mode,
  output logic hit
);

  logic prev_r; // pin level one cycle ago

  // remember last level; reset low so a high pin after reset is a rise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      prev_r <= 1'b0;
    else
      prev_r <= pin;
  end

  // edge selection per mode
  always_comb
  begin
    unique case (mode)
      EDGE_OFF: hit = 1'b0;
      EDGE_RISE: hit = pin & ~prev_r;
      EDGE_FALL: hit = ~pin & prev_r;
      EDGE_BOTH: hit = pin ^ prev_r;
    endcase
  end

endmodule // pin_edge_detect

/* group_irq_reg.sv */
// group_irq_reg: one multi-function group register, flags and enables
// assumes sub-source events are one-cycle pulses on clock
module group_irq_reg
  import irq_pkg::*;
#(
  parameter logic [3:0] MASK = 4'hf
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] events,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] value,
  output logic request
);

  logic [3:0] flags_r; // pending sub-source requests
  logic [3:0] enables_r; // sub-source masks

  // flags: set by event, written by software, set wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flags_r <= REG_RESET[3:0];
    else
      for (int i = 0; i < 4; i++)
        flags_r[i] <= MASK[i] & flag_next(flags_r[i], events[i], wr_en,
          wdata[GROUP_FLAG_LSB + i]);
  end

  // enables: software only; unimplemented positions stay zero
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      enables_r <= REG_RESET[3:0];
    else if (wr_en)
      enables_r <= wdata[3:0] & MASK;
  end

  assign value = {flags_r, enables_r};
  // group asks only for enabled pending sub-sources
  assign request = |(flags_r & enables_r);

endmodule // group_irq_reg

/* irq_request_ctrl.sv */
// irq_request_ctrl: interrupt request and enable logic of the controller
// assumes pins and events synchronous to clock, single-cycle event pulses,
// and a core that vectors on core_irq_req and reports a full stack
//
// Local design decisions: the register offsets and the address-and-strobe port.
module irq_request_ctrl
  import irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire reg_req_t bus,
  output logic [7:0] rdata,
  input wire logic [1:0] ext_pin,
  input wire logic [1:0] timebase_evt,
  input wire logic converter_evt,
  input wire logic [3:0][3:0] group_evt,
  input wire logic stack_full,
  output logic core_irq_req,
  output logic [PEND_W-1:0] core_irq_pending,
  output logic irq
);

  // reset release chain
  logic rst_meta_r; // first stage, read only by second
  logic rst_sync_r; // reset copy used by the whole block

  // register write decodes
  logic wr_edge;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_ctrl_c;
  logic [3:0] wr_group;
  logic wr_evt_clear;
  logic wr_evt_enable;

  // edge select, primary registers
  logic [3:0] edge_sel_r; // two 2-bit pin selectors
  logic global_irq_enable_r; // master gate
  logic [1:0] ext_pin_irq_enable_r;
  logic [1:0] ext_pin_irq_flag_r;
  logic [3:0] group_irq_enable_r;
  logic converter_irq_enable_r;
  logic converter_irq_flag_r;
  logic [1:0] timebase_irq_enable_r;
  logic [1:0] timebase_irq_flag_r;

  // group side
  logic [3:0][7:0] group_value; // read image of each group register
  logic [3:0] group_irq_flag; // group request, derived
  logic [1:0] pin_hit; // edge detector pulses
  // implemented sub-source positions of each group
  localparam logic [3:0][3:0] GROUP_MASKS = {GROUP3_MASK, GROUP2_MASK,
    GROUP1_MASK, GROUP0_MASK};

  // event reporting
  logic [7:0] evt_status_r; // sticky events
  logic [7:0] evt_enable_r; // events allowed onto irq
  logic [7:0] evt_set; // this cycle's events
  logic [7:0] group_flag_prev_r; // for rising group detection
  logic [PEND_W-1:0] pending; // enabled, flagged sources
  logic req_nxt; // next core request level
  logic hold_nxt; // request withheld by stack

  // register images
  logic [7:0] ctrl_a_value;
  logic [7:0] ctrl_b_value;
  logic [7:0] ctrl_c_value;
  logic [7:0] rdata_nxt;

  // async assert, synchronous release through two flops
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // write strobes per register
  always_comb
  begin
    wr_edge = bus.wr && (bus.addr == OFS_EDGE_SEL);
    wr_ctrl_a = bus.wr && (bus.addr == OFS_CTRL_A);
    wr_ctrl_b = bus.wr && (bus.addr == OFS_CTRL_B);
    wr_ctrl_c = bus.wr && (bus.addr == OFS_CTRL_C);
    for (int g = 0; g < 4; g++)
      wr_group[g] = bus.wr && (bus.addr == OFS_GROUP0 + 4'(g));
    wr_evt_clear = bus.wr && (bus.addr == OFS_EVT_CLEAR);
    wr_evt_enable = bus.wr && (bus.addr == OFS_EVT_ENABLE);
  end

  // edge selectors, only the low nibble is stored
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      edge_sel_r <= REG_RESET[3:0];
    else if (wr_edge)
      edge_sel_r <= bus.wdata[3:0];
  end

  // one detector per external pin; pin 1 takes the upper selector
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    pin_edge_detect u_edge (
      .clock(clock),
      .rst_n(rst_sync_r),
      .pin(ext_pin[p]),
      .mode(edge_mode_t'(edge_sel_r[(p ? PIN1_SEL_LSB : PIN0_SEL_LSB) +: 2])),
      .hit(pin_hit[p])
    );
  end

  // primary register a: global, pin and group 0 enables
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      global_irq_enable_r <= 1'b0;
      ext_pin_irq_enable_r <= 2'b00;
      group_irq_enable_r[0] <= 1'b0;
    end
    else if (wr_ctrl_a)
    begin
      global_irq_enable_r <= bus.wdata[A_GLOBAL_EN];
      ext_pin_irq_enable_r <= bus.wdata[A_PIN0_EN +: 2];
      group_irq_enable_r[0] <= bus.wdata[A_MF0_EN];
    end
  end

  // pin flags stay set until software writes a zero
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      ext_pin_irq_flag_r <= 2'b00;
    else
      for (int p = 0; p < 2; p++)
        ext_pin_irq_flag_r[p] <= flag_next(ext_pin_irq_flag_r[p], pin_hit[p],
          wr_ctrl_a, bus.wdata[A_PIN0_FLAG + p]);
  end

  // primary register b: converter, time bases, group 1 enables
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      converter_irq_enable_r <= 1'b0;
      timebase_irq_enable_r <= 2'b00;
      group_irq_enable_r[1] <= 1'b0;
    end
    else if (wr_ctrl_b)
    begin
      converter_irq_enable_r <= bus.wdata[B_ADC_EN];
      timebase_irq_enable_r <= bus.wdata[B_TB0_EN +: 2];
      group_irq_enable_r[1] <= bus.wdata[B_MF1_EN];
    end
  end

  // converter and time base flags, hardware set wins
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      converter_irq_flag_r <= 1'b0;
      timebase_irq_flag_r <= 2'b00;
    end
    else
    begin
      converter_irq_flag_r <= flag_next(converter_irq_flag_r,
        converter_evt, wr_ctrl_b, bus.wdata[B_ADC_FLAG]);
      for (int t = 0; t < 2; t++)
        timebase_irq_flag_r[t] <= flag_next(timebase_irq_flag_r[t],
          timebase_evt[t], wr_ctrl_b, bus.wdata[B_TB0_FLAG + t]);
    end
  end

  // primary register c: group 2 and 3 enables
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      group_irq_enable_r[3:2] <= 2'b00;
    else if (wr_ctrl_c)
    begin
      group_irq_enable_r[2] <= bus.wdata[C_MF2_EN];
      group_irq_enable_r[3] <= bus.wdata[C_MF3_EN];
    end
  end

  // group registers: timers, serial, eeprom, low voltage sources
  for (genvar g = 0; g < 4; g++)
  begin : g_group
    group_irq_reg #(.MASK(GROUP_MASKS[g])) u_group (
      .clock(clock),
      .rst_n(rst_sync_r),
      .events(group_evt[g]),
      .wr_en(wr_group[g]),
      .wdata(bus.wdata),
      .value(group_value[g]),
      .request(group_irq_flag[g])
    );
  end

  // sources that are flagged and individually enabled
  always_comb
  begin
    pending = '0;
    pending[PEND_PIN0 +: 2] = ext_pin_irq_flag_r & ext_pin_irq_enable_r;
    pending[PEND_ADC] = converter_irq_flag_r & converter_irq_enable_r;
    pending[PEND_TB0 +: 2] = timebase_irq_flag_r & timebase_irq_enable_r;
    // group flag already carries sub-source enables
    pending[PEND_MF0] = group_irq_flag[0] & group_irq_enable_r[0];
    pending[PEND_MF1] = group_irq_flag[1] & group_irq_enable_r[1];
    pending[PEND_MF2] = group_irq_flag[2] & group_irq_enable_r[2];
    pending[PEND_MF3] = group_irq_flag[3] & group_irq_enable_r[3];
  end

  // core sees a request only with global enable and stack room
  always_comb
  begin
    req_nxt = global_irq_enable_r & (|pending) & ~stack_full;
    hold_nxt = global_irq_enable_r & (|pending) & stack_full;
  end

  // registered request to the core; core suspends main program on it
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      core_irq_req <= 1'b0;
      core_irq_pending <= '0;
    end
    else
    begin
      core_irq_req <= req_nxt;
      core_irq_pending <= req_nxt ? pending : '0;
    end
  end

  // rising edge of any group request, for the event register
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      group_flag_prev_r <= REG_RESET;
    else
      group_flag_prev_r <= {4'h0, group_irq_flag};
  end

  // events of this cycle
  always_comb
  begin
    evt_set = '0;
    evt_set[EVT_PIN0 +: 2] = pin_hit;
    evt_set[EVT_TB0 +: 2] = timebase_evt;
    evt_set[EVT_ADC] = converter_evt;
    evt_set[EVT_GROUP] = |(group_irq_flag & ~group_flag_prev_r[3:0]);
    evt_set[EVT_REQ] = req_nxt & ~core_irq_req;
    // a full stack holding back a request is worth a look
    evt_set[EVT_STACK_HOLD] = hold_nxt;
  end

  // sticky event bits; a new event beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      evt_status_r <= REG_RESET;
    else if (wr_evt_clear)
      evt_status_r <= (evt_status_r & ~bus.wdata) | evt_set;
    else
      evt_status_r <= evt_status_r | evt_set;
  end

  // event enable register
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      evt_enable_r <= REG_RESET;
    else if (wr_evt_enable)
      evt_enable_r <= bus.wdata;
  end

  // level interrupt from the event side, kept registered
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      irq <= 1'b0;
    else
      irq <= |(((evt_status_r & ~({8{wr_evt_clear}} & bus.wdata))
        | evt_set) & (wr_evt_enable ? bus.wdata : evt_enable_r));
  end

  // read images, unimplemented bits zero
  always_comb
  begin
    ctrl_a_value = '0;
    ctrl_a_value[A_GLOBAL_EN] = global_irq_enable_r;
    ctrl_a_value[A_PIN0_EN +: 2] = ext_pin_irq_enable_r;
    ctrl_a_value[A_MF0_EN] = group_irq_enable_r[0];
    ctrl_a_value[A_PIN0_FLAG +: 2] = ext_pin_irq_flag_r;
    ctrl_a_value[A_MF0_FLAG] = group_irq_flag[0];
    ctrl_b_value = '0;
    ctrl_b_value[B_ADC_EN] = converter_irq_enable_r;
    ctrl_b_value[B_TB0_EN +: 2] = timebase_irq_enable_r;
    ctrl_b_value[B_MF1_EN] = group_irq_enable_r[1];
    ctrl_b_value[B_ADC_FLAG] = converter_irq_flag_r;
    ctrl_b_value[B_TB0_FLAG +: 2] = timebase_irq_flag_r;
    ctrl_b_value[B_MF1_FLAG] = group_irq_flag[1];
    ctrl_c_value = '0;
    ctrl_c_value[C_MF2_EN] = group_irq_enable_r[2];
    ctrl_c_value[C_MF3_EN] = group_irq_enable_r[3];
    ctrl_c_value[C_MF2_FLAG] = group_irq_flag[2];
    ctrl_c_value[C_MF3_FLAG] = group_irq_flag[3];
  end

  // read mux; clear register is write-only and reads zero
  always_comb
  begin
    rdata_nxt = '0;
    if (bus.rd)
    begin
      unique case (bus.addr)
        OFS_EDGE_SEL: rdata_nxt = {4'h0, edge_sel_r} & EDGE_SEL_MASK;
        OFS_CTRL_A: rdata_nxt = ctrl_a_value;
        OFS_CTRL_B: rdata_nxt = ctrl_b_value;
        OFS_CTRL_C: rdata_nxt = ctrl_c_value;
        OFS_GROUP0, OFS_GROUP1, OFS_GROUP2, OFS_GROUP3:
          rdata_nxt = group_value[2'(bus.addr - OFS_GROUP0)];
        OFS_EVT_STATUS: rdata_nxt = evt_status_r;
        OFS_EVT_ENABLE: rdata_nxt = evt_enable_r;
        default: rdata_nxt = '0; // unmapped and clear offsets read zero
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      rdata <= REG_RESET;
    else
      rdata <= rdata_nxt;
  end

endmodule // irq_request_ctrl

/* irq_checker.sv */
// irq_checker: port-level assertions for irq_request_ctrl
// assumes a bind onto the top module and a single clock domain
module irq_checker
  import irq_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire reg_req_t bus,
  input wire logic [7:0] rdata,
  input wire logic stack_full,
  input wire logic core_irq_req,
  input wire logic [PEND_W-1:0] core_irq_pending
);
  timeunit 1ns;
  timeprecision 100ps;

  // everything here samples on the rising edge, quiet in reset
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // a read strobe aimed at one offset
  sequence rd_at(logic [3:0] a);
    bus.rd && bus.addr == a;
  endsequence

  // no read strobe this cycle
  sequence no_rd;
    !bus.rd;
  endsequence

  rdata_idle_a: assert property (no_rd |=> rdata == 8'h00)
    else $error("read data outside the answer cycle");
  sel_upper_a: assert property (rd_at(OFS_EDGE_SEL)
    |=> rdata[7:4] == 4'h0)
    else $error("edge select upper nibble not zero");
  clear_read_a: assert property (rd_at(OFS_EVT_CLEAR)
    |=> rdata == 8'h00)
    else $error("clear register read not zero");
  ctrl_gap_a: assert property (rd_at(OFS_CTRL_C)
    |=> (rdata & 8'hcc) == 8'h00)
    else $error("primary c unused bits not zero");
  group_gap_a: assert property (rd_at(OFS_GROUP2)
    |=> (rdata & 8'h44) == 8'h00)
    else $error("group 2 unused bits not zero");
  unmapped_read_a: assert property (bus.rd
    && bus.addr > OFS_EVT_ENABLE |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  stack_hold_a: assert property (stack_full |=> !core_irq_req)
    else $error("request while stack full");
  pend_idle_a: assert property (!core_irq_req
    |-> core_irq_pending == '0)
    else $error("pending vector without request");
  pend_cause_a: assert property (core_irq_req |-> |core_irq_pending)
    else $error("request without pending source");
endmodule // irq_checker

bind irq_request_ctrl irq_checker chk (.clock(clock), .rst_n(rst_n),
  .bus(bus), .rdata(rdata), .stack_full(stack_full),
  .core_irq_req(core_irq_req), .core_irq_pending(core_irq_pending));

/* core_model.sv */
// core_model: processor core side of the request interface
// assumes level requests; vectoring itself is not modelled
module core_model
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic core_irq_req,
  input wire logic hold_stack,
  output logic stack_full,
  output int unsigned entries
);
  timeunit 1ns;
  timeprecision 100ps;
  logic req_q; // request seen last cycle

  // stack fills one edge after the bench asks for it
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      stack_full <= 1'b0;
    else
      stack_full <= hold_stack;

  // each new request suspends the main program once
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      req_q <= 1'b0;
      entries <= 0;
    end
    else
    begin
      req_q <= core_irq_req;
      entries <= entries + 32'(core_irq_req && !req_q);
    end
endmodule // core_model

/* irq_request_ctrl_test.sv */
// irq_request_ctrl_test: register, edge and request tests of the block
// assumes irq_pkg, core_model and the bound checker are compiled first
module irq_request_ctrl_test
  import irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t bus_q = '0; // register port request
  logic [7:0] rdata;
  logic [1:0] ext_pin = 2'b00;
  logic [1:0] timebase_evt = 2'b00;
  logic converter_evt = 1'b0;
  logic [3:0][3:0] group_evt = '0;
  logic hold_stack = 1'b0; // command to the core model
  logic stack_full, core_irq_req, irq;
  logic [PEND_W-1:0] core_irq_pending;
  int unsigned entries;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] exp_v;
  // read-back after writing all ones: unused and read-only bits drop
  localparam logic [7:0] EXP_FF [8] = '{8'h0f, 8'h3f, 8'h7f, 8'h03,
    8'h33, 8'hff, 8'hbb, 8'h33};

  irq_request_ctrl uut (.clock(clock), .rst_n(rst_n), .bus(bus_q),
    .rdata(rdata), .ext_pin(ext_pin), .timebase_evt(timebase_evt),
    .converter_evt(converter_evt), .group_evt(group_evt),
    .stack_full(stack_full), .core_irq_req(core_irq_req),
    .core_irq_pending(core_irq_pending), .irq(irq));
  core_model model (.clock(clock), .rst_n(rst_n),
    .core_irq_req(core_irq_req), .hold_stack(hold_stack),
    .stack_full(stack_full), .entries(entries));

  // free-running 100 MHz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  // verdict and end of run, the only exit
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one comparison, counted
  task automatic chk(input string name, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_q.wr <= 1'b0;
  endtask

  // one-cycle read strobe; data stands only in the next cycle
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    bus_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_q.rd <= 1'b0;
    #1 chk("rdata", 16'(rdata), 16'(e));
  endtask

  // wait n edges, then let their updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // hang guard: the run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      stop_test;
    end
  end

  // main sequence
  initial
  begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // every register and an unmapped offset read zero after reset
    for (int a = 0; a < 11; a++)
      rd(4'(a), REG_RESET);
    rd(4'hc, 8'h00);
    // all-ones write: implemented bits only, group flags in primary a to c read-only
    for (int a = 0; a < 8; a++)
    begin
      wr(4'(a), 8'hff);
      rd(4'(a), EXP_FF[a]);
      wr(4'(a), 8'h00);
      rd(4'(a), 8'h00);
    end
    wr(OFS_EVT_CLEAR, 8'hff);
    // every edge mode on both pins; flags stay until cleared
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 4; m++)
      begin
        wr(OFS_EDGE_SEL, 8'(m << (2 * p)));
        @(posedge clock);
        ext_pin[p] <= 1'b1;
        tick(2);
        exp_v = 8'h00;
        exp_v[A_PIN0_FLAG + p] = m[0];
        rd(OFS_CTRL_A, exp_v);
        @(posedge clock);
        ext_pin[p] <= 1'b0;
        tick(2);
        exp_v[A_PIN0_FLAG + p] = m[0] | m[1];
        rd(OFS_CTRL_A, exp_v);
        wr(OFS_CTRL_A, 8'h00);
      end
    // converter request reaches the core only when fully enabled
    wr(OFS_CTRL_B, 8'h01);
    wr(OFS_CTRL_A, 8'h01);
    @(posedge clock);
    converter_evt <= 1'b1;
    @(posedge clock);
    converter_evt <= 1'b0;
    tick(2);
    chk("req", 16'(core_irq_req), 16'h1);
    chk("pending", 16'(core_irq_pending), 16'h1 << PEND_ADC);
    hold_stack <= 1'b1;
    tick(3);
    chk("req", 16'(core_irq_req), 16'h0);
    hold_stack <= 1'b0;
    tick(3);
    chk("req", 16'(core_irq_req), 16'h1);
    wr(OFS_CTRL_A, 8'h00);
    tick(2);
    chk("req", 16'(core_irq_req), 16'h0);
    wr(OFS_CTRL_B, 8'h01);
    rd(OFS_CTRL_B, 8'h01);
    // low-voltage sub-source through group 1
    wr(OFS_CTRL_A, 8'h01);
    wr(OFS_CTRL_B, 8'h08);
    wr(OFS_GROUP1, 8'h01);
    @(posedge clock);
    group_evt[1][0] <= 1'b1;
    @(posedge clock);
    group_evt[1][0] <= 1'b0;
    tick(3);
    chk("pending", 16'(core_irq_pending), 16'h1 << PEND_MF1);
    rd(OFS_GROUP1, 8'h11);
    rd(OFS_CTRL_B, 8'h88);
    @(posedge clock);
    timebase_evt <= 2'b01;
    @(posedge clock);
    timebase_evt <= 2'b00;
    rd(OFS_CTRL_B, 8'ha8);
    chk("entries", 16'(entries > 0), 16'h1);
    // sticky status, enable mask and write-one clear
    wr(OFS_EVT_CLEAR, 8'hff);
    wr(OFS_EVT_ENABLE, 8'h10);
    @(posedge clock);
    converter_evt <= 1'b1;
    @(posedge clock);
    converter_evt <= 1'b0;
    tick(1);
    chk("irq", 16'(irq), 16'h1);
    rd(OFS_EVT_STATUS, 8'h10);
    wr(OFS_EVT_ENABLE, 8'h00);
    tick(2);
    chk("irq", 16'(irq), 16'h0);
    wr(OFS_EVT_CLEAR, 8'h10);
    rd(OFS_EVT_STATUS, 8'h00);
    wr(OFS_EVT_ENABLE, 8'h10);
    tick(2);
    chk("irq", 16'(irq), 16'h0);
    stop_test;
  end
endmodule // irq_request_ctrl_test
